/* File: pkg/csmc_map.vh */
`ifndef CSMC_MAP_VH
`define CSMC_MAP_VH

// Register addresses on the special-function register bus
`define CSMC_ADDR_MODE_A 8'hAF
`define CSMC_ADDR_MODE_B 8'hF3
`define CSMC_ADDR_THR_HI 8'hFE
`define CSMC_ADDR_THR_LO 8'hFD
`define CSMC_ADDR_RES_LO 8'hED
`define CSMC_ADDR_RES_HI 8'hEE

// Reset values
`define CSMC_RST_MODE_A 8'h07
`define CSMC_RST_MODE_B 8'h40
`define CSMC_RST_ZERO 8'h00

// Mode A field positions
`define CSMC_A_RSVD 7
`define CSMC_A_POL 6
`define CSMC_A_DR_HI 5
`define CSMC_A_DR_LO 4
`define CSMC_A_WAKE 3
`define CSMC_A_CG_HI 2
`define CSMC_A_CG_LO 0

// Mode B field positions
`define CSMC_B_CR_HI 7
`define CSMC_B_CR_LO 6
`define CSMC_B_DT_HI 5
`define CSMC_B_DT_LO 3
`define CSMC_B_IA_HI 2
`define CSMC_B_IA_LO 0

// Clock rate in MHz
`define CSMC_CLK_MHZ 125

// Primary discharge times in ns
`define CSMC_DT0_NS 750
`define CSMC_DT1_NS 1000
`define CSMC_DT2_NS 1200
`define CSMC_DT3_NS 1500
`define CSMC_DT4_NS 2000
`define CSMC_DT5_NS 3000
`define CSMC_DT6_NS 6000
`define CSMC_DT7_NS 12000

// Secondary reset extensions in ns
`define CSMC_DR1_NS 750
`define CSMC_DR2_NS 1500
`define CSMC_DR3_NS 2250

// Least times round up to whole cycles
`define CSMC_CYC(ns) (((ns) * `CSMC_CLK_MHZ + 999) / 1000)

// Conversion lengths in converter clocks
`define CSMC_CR0_CLK 5'h0C
`define CSMC_CR1_CLK 5'h0D
`define CSMC_CR2_CLK 5'h0E
`define CSMC_CR3_CLK 5'h10

`endif

/* File: src/csmc_mode_config.v */
`timescale 1ns/1ps
`default_nettype none
`include "csmc_map.vh"

// How it works
// - Polarity 0: above threshold; 1: at or below
// - Secondary reset adds 0, 0.75, 1.5, 2.25 us
// - Bit 3 picks the wake-up source
// - Gain equals field value plus one
// - Rate code sets 12, 13, 14, 16 clocks
// - Result width equals selected clock count
// - Discharge code sets primary reset duration
// - Current field scales charge current in eighths
// - Threshold is high and low byte pair
// - Last result held in readable byte pair
module csmc_mode_config #(
	parameter CONV_DIV = 4 // System clocks per converter clock
) (
	input wire clock, // System clock
	input wire rst_n, // Synchronous reset, active low
	input wire [7:0] sfrAddr, // Register address
	input wire [7:0] sfrWdata, // Write data
	input wire sfrWrite, // Write strobe, one cycle
	input wire sfrRead, // Read strobe, one cycle
	input wire convStart, // Start one conversion, one cycle
	input wire sampleBit, // Front end decision bit, MSB first
	output reg [7:0] sfrRdata, // Read data, one cycle after strobe
	output reg dischargeActive, // Primary discharge phase
	output reg secondaryActive, // Secondary reset phase
	output reg converting, // Conversion in progress
	output reg convClock, // Converter clock pulse during conversion
	output reg [3:0] gainValue, // Capacitance gain 1..8
	output reg [3:0] chargeEighths, // Charge current in eighths
	output reg endOfScan, // Conversion done, one cycle
	output reg cmpInterrupt, // Comparator hit, one cycle
	output reg wakeEvent // Wake-up request, one cycle
);

	// Sequencer states
	localparam ST_IDLE = 3'd0;
	localparam ST_DISCH = 3'd1;
	localparam ST_SECOND = 3'd2;
	localparam ST_CONV = 3'd3;
	localparam ST_DONE = 3'd4;

	// Phase lengths in whole cycles; kept as integers, cut to 12 bits on use
	localparam integer DT0_CYC = `CSMC_CYC(`CSMC_DT0_NS);
	localparam integer DT1_CYC = `CSMC_CYC(`CSMC_DT1_NS);
	localparam integer DT2_CYC = `CSMC_CYC(`CSMC_DT2_NS);
	localparam integer DT3_CYC = `CSMC_CYC(`CSMC_DT3_NS);
	localparam integer DT4_CYC = `CSMC_CYC(`CSMC_DT4_NS);
	localparam integer DT5_CYC = `CSMC_CYC(`CSMC_DT5_NS);
	localparam integer DT6_CYC = `CSMC_CYC(`CSMC_DT6_NS);
	localparam integer DT7_CYC = `CSMC_CYC(`CSMC_DT7_NS);
	localparam integer DR1_CYC = `CSMC_CYC(`CSMC_DR1_NS);
	localparam integer DR2_CYC = `CSMC_CYC(`CSMC_DR2_NS);
	localparam integer DR3_CYC = `CSMC_CYC(`CSMC_DR3_NS);

	reg [7:0] modeA; // First mode register
	reg [7:0] modeB; // Second mode register
	reg [7:0] thrHigh; // Threshold high byte
	reg [7:0] thrLow; // Threshold low byte
	reg [15:0] result; // Last completed conversion
	reg [15:0] shiftReg; // Bits gathered during conversion
	reg [2:0] state; // Sequencer state
	reg [11:0] phaseCount; // Remaining cycles of a timed phase
	reg [4:0] bitCount; // Converter clocks left
	reg [7:0] divCount; // Converter clock divider
	reg [2:0] next_state; // Next sequencer state
	reg [11:0] dischCycles; // Primary discharge length
	reg [11:0] secondCycles; // Secondary extension length
	reg [4:0] convClocks; // Converter clocks per conversion
	reg hit; // Comparator decision on the new result
	reg [15:0] newResult; // Shift register with sampleBit appended, combinational; taken into shiftReg each converter clock
	wire [15:0] threshold; // Assembled threshold
	wire divTick; // Converter clock enable

	assign threshold = {thrHigh, thrLow};
	assign divTick = (divCount == (CONV_DIV[7:0] - 8'h01));

	// Primary discharge length from its code; 111 doubles 110
	always @* begin
		case (modeB[`CSMC_B_DT_HI:`CSMC_B_DT_LO])
		3'b000: dischCycles = DT0_CYC[11:0];
		3'b001: dischCycles = DT1_CYC[11:0];
		3'b010: dischCycles = DT2_CYC[11:0];
		3'b011: dischCycles = DT3_CYC[11:0];
		3'b100: dischCycles = DT4_CYC[11:0];
		3'b101: dischCycles = DT5_CYC[11:0];
		3'b110: dischCycles = DT6_CYC[11:0];
		default: dischCycles = DT7_CYC[11:0];
		endcase
	end

	// Secondary extension; code 00 skips the phase entirely
	always @* begin
		case (modeA[`CSMC_A_DR_HI:`CSMC_A_DR_LO])
		2'b00: secondCycles = 12'h000;
		2'b01: secondCycles = DR1_CYC[11:0];
		2'b10: secondCycles = DR2_CYC[11:0];
		default: secondCycles = DR3_CYC[11:0];
		endcase
	end

	// Conversion length in converter clocks
	always @* begin
		case (modeB[`CSMC_B_CR_HI:`CSMC_B_CR_LO])
		2'b00: convClocks = `CSMC_CR0_CLK;
		2'b01: convClocks = `CSMC_CR1_CLK;
		2'b10: convClocks = `CSMC_CR2_CLK;
		default: convClocks = `CSMC_CR3_CLK;
		endcase
	end

	// One bit gathered per converter clock, so width tracks length
	always @* begin
		newResult = {shiftReg[14:0], sampleBit};
		if (modeA[`CSMC_A_POL]) begin
			hit = (shiftReg <= threshold);
		end else begin
			hit = (shiftReg > threshold);
		end
	end

	// Sequencer next state
	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (convStart) begin
				next_state = ST_DISCH;
			end
		end
		ST_DISCH: begin
			if (phaseCount == 12'h001) begin
				next_state = (secondCycles == 12'h000) ?
					ST_CONV : ST_SECOND;
			end
		end
		ST_SECOND: begin
			if (phaseCount == 12'h001) begin
				next_state = ST_CONV;
			end
		end
		ST_CONV: begin
			if (divTick && bitCount == 5'd1) begin
				next_state = ST_DONE;
			end
		end
		ST_DONE: next_state = ST_IDLE;
		default: next_state = ST_IDLE;
		endcase
	end

	// Register file writes; reserved bit is stored as written
	always @(posedge clock) begin
		if (!rst_n) begin
			modeA <= `CSMC_RST_MODE_A;
			modeB <= `CSMC_RST_MODE_B;
			thrHigh <= `CSMC_RST_ZERO;
			thrLow <= `CSMC_RST_ZERO;
		end else if (sfrWrite) begin
			case (sfrAddr)
			`CSMC_ADDR_MODE_A: modeA <= sfrWdata;
			`CSMC_ADDR_MODE_B: modeB <= sfrWdata;
			`CSMC_ADDR_THR_HI: thrHigh <= sfrWdata;
			`CSMC_ADDR_THR_LO: thrLow <= sfrWdata;
			default: ;
			endcase
		end
	end

	// Read data; unmapped addresses return zero
	always @(posedge clock) begin
		if (!rst_n) begin
			sfrRdata <= 8'h00;
		end else if (sfrRead) begin
			case (sfrAddr)
			`CSMC_ADDR_MODE_A: sfrRdata <= modeA;
			`CSMC_ADDR_MODE_B: sfrRdata <= modeB;
			`CSMC_ADDR_THR_HI: sfrRdata <= thrHigh;
			`CSMC_ADDR_THR_LO: sfrRdata <= thrLow;
			`CSMC_ADDR_RES_LO: sfrRdata <= result[7:0];
			`CSMC_ADDR_RES_HI: sfrRdata <= result[15:8];
			default: sfrRdata <= 8'h00;
			endcase
		end
	end

	// Sequencer, divider and result capture
	always @(posedge clock) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			phaseCount <= 12'h000;
			bitCount <= 5'd0;
			divCount <= 8'h00;
			shiftReg <= 16'h0000;
			result <= 16'h0000;
		end else begin
			state <= next_state;
			// Divider runs only while converting so every bit is full length
			if (state == ST_CONV && !divTick) begin
				divCount <= divCount + 8'h01;
			end else begin
				divCount <= 8'h00;
			end
			case (state)
			ST_IDLE: begin
				phaseCount <= dischCycles;
				shiftReg <= 16'h0000;
			end
			ST_DISCH: begin
				phaseCount <= (phaseCount == 12'h001) ?
					secondCycles : phaseCount - 12'h001;
				bitCount <= convClocks;
			end
			ST_SECOND: begin
				phaseCount <= phaseCount - 12'h001;
				bitCount <= convClocks;
			end
			ST_CONV: begin
				if (divTick) begin
					shiftReg <= newResult;
					bitCount <= bitCount - 5'd1;
				end
			end
			ST_DONE: result <= shiftReg;
			default: ;
			endcase
		end
	end

	// Registered outputs; events fire in the cycle the result is latched
	always @(posedge clock) begin
		if (!rst_n) begin
			dischargeActive <= 1'b0;
			secondaryActive <= 1'b0;
			converting <= 1'b0;
			convClock <= 1'b0;
			gainValue <= 4'h8;
			chargeEighths <= 4'h8;
			endOfScan <= 1'b0;
			cmpInterrupt <= 1'b0;
			wakeEvent <= 1'b0;
		end else begin
			dischargeActive <= (next_state == ST_DISCH);
			secondaryActive <= (next_state == ST_SECOND);
			converting <= (next_state == ST_CONV);
			convClock <= (state == ST_CONV) && divTick;
			gainValue <= {1'b0, modeA[`CSMC_A_CG_HI:`CSMC_A_CG_LO]}
				+ 4'h1;
			// Code 000 means full current, others are n eighths
			if (modeB[`CSMC_B_IA_HI:`CSMC_B_IA_LO] == 3'b000) begin
				chargeEighths <= 4'h8;
			end else begin
				chargeEighths <= {1'b0,
					modeB[`CSMC_B_IA_HI:`CSMC_B_IA_LO]};
			end
			endOfScan <= (state == ST_DONE);
			cmpInterrupt <= (state == ST_DONE) && hit;
			// Wake select 1 adds end of scan as a source
			wakeEvent <= (state == ST_DONE) && (hit ||
				modeA[`CSMC_A_WAKE]);
		end
	end

endmodule // csmc_mode_config
`default_nettype wire

/* File: tb/csmc_mode_config_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csmc_map.vh"
module csmc_mode_config_bench;
	reg clock = 0; // Clock
	reg rst_n = 0; // Reset, low
	reg [7:0] sfrAddr = 8'h00; // Address
	reg [7:0] sfrWdata = 8'h00; // Write data
	reg sfrWrite = 0, sfrRead = 0, convStart = 0, sampleBit = 0; // Strobes
	wire [7:0] sfrRdata;
	wire dischargeActive, secondaryActive, converting, convClock;
	wire [3:0] gainValue, chargeEighths;
	wire endOfScan, cmpInterrupt, wakeEvent;
	integer mismatches = 0, n_tests = 0;
	reg [7:0] rdQ[$]; // Expected read data
	reg [1:0] evQ[$]; // Expected hit and wake
	reg [7:0] lfsr = 8'h3D; // Random source
	localparam DIV = 4; // Converter clock divider under test
	always #4 clock = ~clock;
	csmc_mode_config #(.CONV_DIV(DIV)) csmc_mode_config_i (.clock, .rst_n,
		.sfrAddr, .sfrWdata,
		.sfrWrite, .sfrRead, .convStart, .sampleBit, .sfrRdata,
		.dischargeActive, .secondaryActive, .converting, .convClock,
		.gainValue, .chargeEighths, .endOfScan, .cmpInterrupt, .wakeEvent);
	function [7:0] rnd(input [7:0] s);
		rnd = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Primary discharge cycles per code, rounded up at 8 ns
	function [15:0] disExp(input [2:0] c);
		case (c)
		3'h0: disExp = 16'h005E;
		3'h1: disExp = 16'h007D;
		3'h2: disExp = 16'h0096;
		3'h3: disExp = 16'h00BC;
		3'h4: disExp = 16'h00FA;
		3'h5: disExp = 16'h0177;
		3'h6: disExp = 16'h02EE;
		default: disExp = 16'h05DC;
		endcase
	endfunction
	task check(input [15:0] seen, input [15:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Inputs move 1 ns after the edge so the design samples them cleanly
	task tick;
		@(posedge clock);
		#1;
	endtask
	task wr(input [7:0] a, input [7:0] d);
		sfrAddr = a;
		sfrWdata = d;
		sfrWrite = 1;
		tick;
		sfrWrite = 0;
		tick;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		rdQ.push_back(e);
		sfrAddr = a;
		sfrRead = 1;
		tick;
		sfrRead = 0;
		tick;
	endtask
	// Watcher: compares each answer with the oldest note once it settles
	always @(posedge clock) begin : watch
		reg took;
		took = sfrRead;
		#2;
		if (took) check({8'h00, sfrRdata}, {8'h00, rdQ.pop_front()});
		if (endOfScan) check({cmpInterrupt, wakeEvent}, evQ.pop_front());
	end
	initial begin : main
		integer j, k, t, n;
		reg [15:0] v, thr, dis, sec, cv, cc;
		reg hit;
		repeat (12) tick;
		rst_n = 1;
		rd(`CSMC_ADDR_MODE_A, `CSMC_RST_MODE_A);
		rd(`CSMC_ADDR_MODE_B, `CSMC_RST_MODE_B);
		rd(8'h10, 8'h00);
		wr(`CSMC_ADDR_RES_LO, 8'hA5);
		rd(`CSMC_ADDR_RES_LO, 8'h00);
		$display("test registers done");
		// Sweep every gain and current code; top bit kept zero
		for (j = 0; j < 8; j = j + 1) begin
			wr(`CSMC_ADDR_MODE_A, j[7:0]);
			wr(`CSMC_ADDR_MODE_B, j[7:0]);
			check({12'h000, gainValue}, j[15:0] + 16'h0001);
			check({12'h000, chargeEighths}, j ? j[15:0] : 16'h0008);
		end
		$display("test codes done");
		// Each rate, timing code and polarity; threshold on the boundary
		for (j = 0; j < 8; j = j + 1) begin
			lfsr = rnd(lfsr);
			v[15:8] = lfsr;
			lfsr = rnd(lfsr);
			v[7:0] = lfsr;
			k = (j % 4 == 3) ? 16 : 12 + j % 4;
			v = (v >> (16 - k)) | 16'h0001;
			thr = j[2] ? v - 16'h0001 : v;
			wr(`CSMC_ADDR_MODE_A, {1'b0, j[0], j[1:0], j[1], 3'h7});
			wr(`CSMC_ADDR_MODE_B, {j[1:0], j[2], j[1:0], 3'h0});
			wr(`CSMC_ADDR_THR_HI, thr[15:8]);
			wr(`CSMC_ADDR_THR_LO, thr[7:0]);
			hit = j[0] ? v <= thr : v > thr;
			evQ.push_back({hit, hit | j[1]});
			n = k;
			k = k - 1;
			sampleBit = v[k];
			dis = 16'h0000;
			sec = 16'h0000;
			cv = 16'h0000;
			cc = 16'h0000;
			convStart = 1;
			tick;
			convStart = 0;
			for (t = 0; t < 3000 && !endOfScan; t = t + 1) begin
				dis = dis + dischargeActive;
				sec = sec + secondaryActive;
				cv = cv + converting;
				cc = cc + convClock;
				if (convClock && k > 0) begin
					k = k - 1;
					sampleBit = v[k];
				end
				tick;
			end
			if (t == 3000) begin
				mismatches = mismatches + 1;
				complete_run;
			end
			check(dis, disExp(j[2:0]));
			check(sec, j[1] ? (j[0] ? 16'h011A : 16'h00BC) :
				(j[0] ? 16'h005E : 16'h0000));
			check(cc, n);
			check(cv, n * DIV);
			rd(`CSMC_ADDR_RES_HI, v[15:8]);
			rd(`CSMC_ADDR_RES_LO, v[7:0]);
			$display("test conversion %0d done", j);
		end
		complete_run;
	end
endmodule // csmc_mode_config_bench
`default_nettype wire

/* File: tb/csmc_mode_config_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csmc_map.vh"
module csmc_chk (
	input wire clock, // Clock
	input wire rst_n, // Reset, low
	input wire [7:0] sfrAddr, // Address
	input wire [7:0] sfrWdata, // Write data
	input wire sfrWrite, // Write strobe
	input wire sfrRead, // Read strobe
	input wire convStart, // Start
	input wire [7:0] sfrRdata, // Read data
	input wire dischargeActive, // Discharge
	input wire secondaryActive, // Secondary
	input wire converting, // Converting
	input wire convClock, // Converter clock
	input wire [3:0] gainValue, // Gain
	input wire [3:0] chargeEighths, // Current
	input wire endOfScan, // Done
	input wire cmpInterrupt, // Hit
	input wire wakeEvent // Wake
);
	reg [7:0] mA; // Mode A mirror
	reg [7:0] mB; // Mode B mirror
	reg [4:0] nPulse; // Converter clocks seen
	wire [4:0] nExp = mB[7] ? (mB[6] ? 5'h10 : 5'h0E) : (mB[6] ? 5'h0D : 5'h0C);
	wire idle = !dischargeActive && !secondaryActive && !converting && !endOfScan;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Mirrors follow writes; pulse count restarts with each discharge
	always @(posedge clock) begin
		if (!rst_n) begin
			mA <= `CSMC_RST_MODE_A;
			mB <= `CSMC_RST_MODE_B;
			nPulse <= 5'h00;
		end else begin
			if (sfrWrite && sfrAddr == `CSMC_ADDR_MODE_A) mA <= sfrWdata;
			if (sfrWrite && sfrAddr == `CSMC_ADDR_MODE_B) mB <= sfrWdata;
			if (dischargeActive) nPulse <= 5'h00;
			else if (convClock) nPulse <= nPulse + 5'h01;
		end
	end
	sequence sStart;
		convStart && idle && !$past(converting);
	endsequence
	chk_start_discharge: assert property (
		sStart |=> dischargeActive) else $error("start lost");
	chk_gain_value: assert property (
		!$past(sfrWrite) && !$past(sfrWrite, 2) |->
		gainValue == {1'b0, mA[2:0]} + 4'h1) else $error("gain wrong");
	chk_charge_value: assert property (
		!$past(sfrWrite) && !$past(sfrWrite, 2) |-> chargeEighths ==
		(mB[2:0] == 3'h0 ? 4'h8 : {1'b0, mB[2:0]})) else $error("charge wrong");
	chk_read_modea: assert property (
		sfrRead && !sfrWrite && sfrAddr == `CSMC_ADDR_MODE_A |=>
		sfrRdata == $past(mA)) else $error("mode A read wrong");
	chk_read_modeb: assert property (
		sfrRead && !sfrWrite && sfrAddr == `CSMC_ADDR_MODE_B |=>
		sfrRdata == $past(mB)) else $error("mode B read wrong");
	chk_rdata_hold: assert property (
		!sfrRead |=> $stable(sfrRdata)) else $error("read data moved");
	chk_hit_pair: assert property (
		cmpInterrupt |-> endOfScan) else $error("hit without end");
	chk_wake_cause: assert property (
		wakeEvent == (cmpInterrupt || (endOfScan && $past(mA[3]))))
		else $error("wake wrong");
	chk_pulse_count: assert property (
		endOfScan |=> nPulse == nExp) else $error("clock count wrong");
endmodule // csmc_chk
bind csmc_mode_config csmc_chk csmc_chk_i (.clock, .rst_n, .sfrAddr,
	.sfrWdata, .sfrWrite, .sfrRead, .convStart, .sfrRdata, .dischargeActive,
	.secondaryActive, .converting, .convClock, .gainValue, .chargeEighths,
	.endOfScan, .cmpInterrupt, .wakeEvent);
`default_nettype wire
